// ===== design/coeff_divider.sv
// sequential signed divide of a 17-bit value by an unsigned byte
`timescale 1ns/1ps
module coeff_divider (
  input wire logic clock,
  input wire logic rst,
  input wire logic start,
  input wire logic signed [16:0] dividend,
  input wire logic [7:0] divisor,
  output logic signed [16:0] quotient,
  output logic done
);
  import loop_pkg::*;
  typedef struct packed {
    logic busy;
    logic neg;
    logic [4:0] count;
    logic [8:0] rem;
    logic [16:0] work;
    logic [7:0] den;
    logic signed [16:0] q;
    logic done;
  } div_state_type;
  div_state_type st, next_st;

  ////////////////////////////////////////////////////////////////////////
  // restoring division on the magnitude, quotient truncates toward zero
  always_comb begin
    logic [8:0] sh;
    sh = 9'h000;
    next_st = st;
    next_st.done = 1'b0;
    if (start && !st.busy) begin
      next_st.busy = 1'b1;
      next_st.neg = dividend[16];
      next_st.work = dividend[16] ? 17'(-dividend) : dividend;
      next_st.den = divisor;
      next_st.rem = 9'h000;
      next_st.count = DIV_STEPS;
    end else if (st.busy) begin
      sh = {st.rem[7:0], st.work[16]};
      next_st.work = {st.work[15:0], 1'b0};
      if (sh >= {1'b0, st.den}) begin
        next_st.rem = sh - {1'b0, st.den};
        next_st.work[0] = 1'b1;
      end else begin
        next_st.rem = sh;
      end
      next_st.count = st.count - 5'h01;
      if (st.count == 5'h01) begin
        next_st.busy = 1'b0;
        next_st.done = 1'b1;
        next_st.q = st.neg ? 17'(-next_st.work) : next_st.work;
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) st <= '0;
    else st <= next_st;
  end

  assign quotient = st.q;
  assign done = st.done;
endmodule // coeff_divider

// ===== design/loop_framer.sv
// real-time loop framer: control block parser, feedback block builder, register slave
// How it works
// - velocity byte then gain byte per selected motor when their flags are set
// - received velocity byte is multiplied by the motor's control coefficient
// - feedback velocity byte per selected motor when its flag is set
// - actual velocity divided by feedback velocity coefficient gives that byte
// - strain byte per selected motor when its flag is set
// - two-byte absolute position per selected motor when its flag is set
// - signed delta position byte per selected motor when its flag is set
// - position change divided by delta coefficient gives the delta byte
// - discard flag drops delta overflow instead of carrying it forward
// - temperature word follows all motor data when its global flag is set
// - motor order, strain before delta, only motors selected at loop entry
// - loop entry sends one asterisk then waits for control blocks
// - header C carries data and is answered with one feedback block
// - byte 03 ends the loop; a prompt is sent and command mode resumes
// - c data plus ack, A no data plus feedback, a no data plus ack
// - control byte is four integer four fraction; feedback byte is integer
// - delta against last reported position, clipped, reported advanced by sent times delta coefficient
// - error replaces next reply header with CR LF ERR number, loop exits
`timescale 1ns/1ps
module loop_framer (
  input wire logic clock,
  input wire logic rst,
  input wire logic [4:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [7:0] rx_data,
  input wire logic rx_valid,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic [63:0] motor_velocity,
  input wire logic [31:0] motor_strain,
  input wire logic [63:0] motor_position,
  input wire logic [15:0] temperature,
  input wire logic err_event,
  input wire logic [3:0] err_code,
  output logic [63:0] ctl_velocity,
  output logic [31:0] ctl_gain,
  output logic ctl_update,
  output logic loop_active
);
  import loop_pkg::*;
  typedef struct packed {
    fsm_type state;
    fsm_type ret;
    msg_type msg_kind;
    logic [2:0] msg_idx;
    logic [2:0] motor;
    logic [2:0] item;
    logic [1:0] cur_m;
    logic in_loop;
    logic [3:0] sel;
    logic [3:0][5:0] flags;
    logic [3:0][7:0] cvc;
    logic [3:0][7:0] fvc;
    logic [3:0][7:0] dpc;
    logic temp_inc;
    logic discard;
    logic err_pend;
    logic [3:0] err_num;
    logic hdr_fb;
    logic [7:0] tx_data;
    logic [3:0][7:0] stage_v;
    logic [3:0][7:0] stage_g;
    logic [7:0] got;
    logic [3:0][15:0] cmd_vel;
    logic [3:0][7:0] cmd_gain;
    logic ctl_update;
    logic div_go;
    logic div_delta;
    logic signed [16:0] div_num;
    logic [7:0] div_den;
    logic trk_load;
    logic trk_update;
    logic [7:0] trk_sent;
    logic [7:0] last_hdr;
    logic [15:0] block_count;
    logic bus_ack;
    logic [31:0] readdata;
  } framer_state_type;
  framer_state_type st, next_st;
  logic signed [16:0] div_q;
  logic div_done;
  logic [63:0] reported;
  logic bus_req;

  // scaling divider shared by velocity and delta feedback
  coeff_divider u_div (
    .clock(clock), .rst(rst), .start(st.div_go), .dividend(st.div_num),
    .divisor(st.div_den), .quotient(div_q), .done(div_done)
  );

  // last reported positions for delta feedback
  position_tracker #(.MOTORS(NUM_MOTORS)) u_trk (
    .clock(clock), .rst(rst), .load(st.trk_load), .update(st.trk_update),
    .motor(st.cur_m), .sent(st.trk_sent), .coeff(st.dpc[st.cur_m]), .discard(st.discard),
    .position(motor_position), .reported(reported)
  );

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // byte of a fixed reply string
  function automatic logic [7:0] msg_byte(input msg_type k, input logic [2:0] i, input logic [3:0] e);
    logic [7:0] b;
    b = CH_STAR;
    if (k == MSG_PROMPT) b = CH_PROMPT;
    else if (k == MSG_ERR) begin
      case (i)
        3'h0: b = CH_CR;
        3'h1: b = CH_LF;
        3'h2: b = CH_E;
        3'h3, 3'h4: b = CH_R;
        default: b = (e < 4'ha) ? CH_ZERO + {4'h0, e} : 8'h37 + {4'h0, e};
      endcase
    end
    return b;
  endfunction

  function automatic logic [2:0] msg_len(input msg_type k);
    return (k == MSG_ERR) ? LEN_ERR : (k == MSG_PROMPT) ? LEN_PROMPT : LEN_ACK;
  endfunction

  // is this feedback slot present; motor 4 stands for the global datum
  function automatic logic fb_en(input framer_state_type s);
    logic en;
    en = 1'b0;
    if (s.motor == 3'h4) en = s.temp_inc && (s.item < 3'h2);
    else if (s.motor < 3'h4 && s.sel[s.motor[1:0]]) begin
      case (s.item)
        3'h0: en = s.flags[s.motor[1:0]][F_FV];
        3'h1: en = s.flags[s.motor[1:0]][F_FS];
        3'h2, 3'h3: en = s.flags[s.motor[1:0]][F_FA];
        3'h4: en = s.flags[s.motor[1:0]][F_FD];
        default: en = 1'b0;
      endcase
    end
    return en;
  endfunction

  // answer a finished block: error text, or header star and maybe data
  function automatic framer_state_type start_reply(input framer_state_type s);
    framer_state_type r;
    r = s;
    r.state = S_MSG;
    r.msg_idx = 3'h0;
    r.motor = 3'h0;
    r.item = 3'h0;
    r.msg_kind = s.err_pend ? MSG_ERR : MSG_ACK;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // next-state logic
  assign bus_req = read || write;
  always_comb begin
    logic [31:0] cur;
    logic [31:0] mw;
    logic [1:0] m;
    cur = 32'h0;
    mw = 32'h0;
    m = st.motor[1:0];
    next_st = st;
    next_st.ctl_update = 1'b0;
    next_st.div_go = 1'b0;
    next_st.trk_load = 1'b0;
    next_st.trk_update = 1'b0;
    // error event latch; a new event wins over the clear at loop exit
    if (err_event && st.in_loop) begin
      next_st.err_pend = 1'b1;
      next_st.err_num = err_code;
    end

    // register slave: one wait state, read data ready in the ack cycle
    next_st.bus_ack = bus_req && !st.bus_ack;
    if (bus_req && !st.bus_ack) begin
      case (address)
        OFS_MOTOR0, OFS_MOTOR1, OFS_MOTOR2, OFS_MOTOR3:
          next_st.readdata = {st.dpc[address[3:2]], st.fvc[address[3:2]], st.cvc[address[3:2]],
                              2'b00, st.flags[address[3:2]]};
        OFS_GLOBAL: next_st.readdata = {30'h0, st.discard, st.temp_inc};
        OFS_LOOP: next_st.readdata = {23'h0, st.in_loop, 4'h0, st.sel};
        OFS_STATUS: next_st.readdata = {st.block_count, st.last_hdr, 3'h0, st.err_pend, st.err_num};
        default: next_st.readdata = 32'h0;
      endcase
    end
    // block layout is frozen while the loop runs
    if (write && st.bus_ack && !st.in_loop) begin
      case (address)
        OFS_MOTOR0, OFS_MOTOR1, OFS_MOTOR2, OFS_MOTOR3: begin
          cur = {st.dpc[address[3:2]], st.fvc[address[3:2]], st.cvc[address[3:2]], 2'b00, st.flags[address[3:2]]};
          mw = be_merge(cur, writedata, byteenable);
          next_st.flags[address[3:2]] = mw[5:0];
          next_st.cvc[address[3:2]] = nz(mw[POS_CVC +: 8]);
          next_st.fvc[address[3:2]] = nz(mw[POS_FVC +: 8]);
          next_st.dpc[address[3:2]] = nz(mw[POS_DPC +: 8]);
        end
        OFS_GLOBAL: begin
          if (byteenable[0]) next_st.temp_inc = writedata[G_TEMP];
          if (byteenable[0]) next_st.discard = writedata[G_DISCARD];
        end
        OFS_LOOP: begin
          if (byteenable[0] && st.state == S_IDLE) begin
            next_st.sel = writedata[3:0];
            next_st.in_loop = 1'b1;
            next_st.trk_load = 1'b1;
            next_st.err_pend = 1'b0;
            next_st.hdr_fb = 1'b0;
            next_st.msg_kind = MSG_ACK;
            next_st.msg_idx = 3'h0;
            next_st.state = S_MSG;
          end
        end
        default: ;
      endcase
    end

    case (st.state)
      S_IDLE: ;
      S_MSG: begin
        if (st.msg_idx != msg_len(st.msg_kind)) begin
          next_st.tx_data = msg_byte(st.msg_kind, st.msg_idx, st.err_num);
          next_st.msg_idx = st.msg_idx + 3'h1;
          next_st.ret = S_MSG;
          next_st.state = S_SEND;
        end else if (st.msg_kind == MSG_ACK) begin
          next_st.state = st.hdr_fb ? S_FSEEK : S_HDR;
        end else begin
          next_st.in_loop = 1'b0;
          next_st.state = S_IDLE;
          if (st.msg_kind == MSG_ERR && !(err_event && st.in_loop)) next_st.err_pend = 1'b0;
        end
      end
      S_SEND: begin
        if (tx_ready) next_st.state = st.ret;
      end
      S_HDR: begin
        if (rx_valid) begin
          next_st.last_hdr = rx_data;
          case (rx_data)
            HDR_CF, HDR_CA: begin
              next_st.hdr_fb = (rx_data == HDR_CF);
              next_st.motor = 3'h0;
              next_st.item = 3'h0;
              next_st.got = 8'h00;
              next_st.state = S_CSEEK;
            end
            HDR_NF, HDR_NA: begin
              next_st = start_reply(next_st);
              next_st.hdr_fb = (rx_data == HDR_NF);
            end
            CH_ETX: begin
              next_st.msg_kind = MSG_PROMPT;
              next_st.msg_idx = 3'h0;
              next_st.state = S_MSG;
            end
            default: ;
          endcase
        end
      end
      S_CSEEK: begin
        if (st.motor == 3'h4) begin
          for (int i = 0; i < NUM_MOTORS; i++) begin
            if (st.got[2*i]) next_st.cmd_vel[i] = mul_coeff(st.stage_v[i], st.cvc[i]);
            if (st.got[2*i+1]) next_st.cmd_gain[i] = st.stage_g[i];
          end
          next_st.ctl_update = 1'b1;
          next_st.block_count = st.block_count + 16'h0001;
          next_st = start_reply(next_st);
        end else if (st.sel[m] && st.flags[m][st.item[0] ? F_CG : F_CV]) begin
          next_st.state = S_CRECV;
        end else begin
          next_st.item = st.item[0] ? 3'h0 : 3'h1;
          next_st.motor = st.item[0] ? st.motor + 3'h1 : st.motor;
        end
      end
      S_CRECV: begin
        if (rx_valid) begin
          if (st.item[0]) next_st.stage_g[m] = rx_data;
          else next_st.stage_v[m] = rx_data;
          next_st.got[{m, st.item[0]}] = 1'b1;
          next_st.item = st.item[0] ? 3'h0 : 3'h1;
          next_st.motor = st.item[0] ? st.motor + 3'h1 : st.motor;
          next_st.state = S_CSEEK;
        end
      end
      S_FSEEK: begin
        if (st.motor == 3'h5) begin
          next_st.state = S_HDR;
        end else begin
          if (st.item == ((st.motor == 3'h4) ? 3'h1 : 3'h4)) begin
            next_st.item = 3'h0;
            next_st.motor = st.motor + 3'h1;
          end else begin
            next_st.item = st.item + 3'h1;
          end
          if (fb_en(st)) begin
            next_st.cur_m = m;
            next_st.ret = S_FSEEK;
            next_st.state = S_SEND;
            if (st.motor == 3'h4) begin
              next_st.tx_data = st.item[0] ? temperature[7:0] : temperature[15:8];
            end else begin
              case (st.item)
                3'h0: begin
                  next_st.div_num = {motor_velocity[m*16 + 15], motor_velocity[m*16 +: 16]};
                  next_st.div_den = st.fvc[m];
                  next_st.div_delta = 1'b0;
                  next_st.div_go = 1'b1;
                  next_st.state = S_FDIV;
                end
                3'h1: next_st.tx_data = motor_strain[m*8 +: 8];
                3'h2: next_st.tx_data = motor_position[m*16 + 8 +: 8];
                3'h3: next_st.tx_data = motor_position[m*16 +: 8];
                default: begin
                  next_st.div_num = 17'({1'b0, motor_position[m*16 +: 16]}) - 17'({1'b0, reported[m*16 +: 16]});
                  next_st.div_den = st.dpc[m];
                  next_st.div_delta = 1'b1;
                  next_st.div_go = 1'b1;
                  next_st.state = S_FDIV;
                end
              endcase
            end
          end
        end
      end
      S_FDIV: begin
        if (div_done) begin
          next_st.tx_data = clip8(div_q);
          next_st.trk_sent = clip8(div_q);
          next_st.trk_update = st.div_delta;
          next_st.state = S_SEND;
        end
      end
      default: next_st.state = S_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.state <= S_IDLE;
      st.ret <= S_IDLE;
      st.flags <= {NUM_MOTORS{RST_FLAGS}};
      st.cvc <= {NUM_MOTORS{RST_COEFF}};
      st.fvc <= {NUM_MOTORS{RST_COEFF}};
      st.dpc <= {NUM_MOTORS{RST_COEFF}};
    end else begin
      st <= next_st;
    end
  end

  // rx read only in S_HDR, S_CRECV; outputs follow
  assign readdata = st.readdata;
  assign waitrequest = bus_req && !st.bus_ack;
  assign tx_data = st.tx_data;
  assign tx_valid = (st.state == S_SEND);
  assign ctl_velocity = st.cmd_vel;
  assign ctl_gain = st.cmd_gain;
  assign ctl_update = st.ctl_update;
  assign loop_active = st.in_loop;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  a_entry_ack: assert property (write && st.bus_ack && address == OFS_LOOP && byteenable[0] &&
    st.state == S_IDLE && !st.in_loop |=> ##1 tx_valid && tx_data == CH_STAR) else $error("no star on entry");
  a_header_star: assert property (st.state == S_MSG && st.msg_kind == MSG_ACK && st.msg_idx == 3'h0
    |=> tx_valid && tx_data == CH_STAR) else $error("reply header not star");
  a_etx_prompt: assert property (st.state == S_HDR && rx_valid && rx_data == CH_ETX
    |=> ##1 tx_valid && tx_data == CH_PROMPT) else $error("no prompt after terminate");
  a_err_text: assert property (st.state == S_MSG && st.msg_kind == MSG_ERR && st.msg_idx == 3'h0
    |=> tx_data == CH_CR) else $error("error text not first");
  a_vel_scaled: assert property (ctl_update && st.got[0]
    |-> st.cmd_vel[0] == mul_coeff(st.stage_v[0], st.cvc[0])) else $error("velocity not scaled");
  a_delta_clip: assert property (st.state == S_FDIV && div_done
    |=> tx_valid && tx_data == clip8($past(div_q))) else $error("divided byte not clipped");
  a_coeff_range: assert property (st.fvc[0] != 8'h00 && st.dpc[0] != 8'h00 && st.cvc[0] != 8'h00)
    else $error("coefficient reached zero");
  a_recv_wait: assert property (st.state == S_CRECV && !rx_valid |=> st.state == S_CRECV)
    else $error("control byte skipped");
  a_temp_low: assert property (st.state == S_FSEEK && st.motor == 3'h4 && st.item == 3'h1 && st.temp_inc
    |=> tx_data == $past(temperature[7:0])) else $error("temperature low byte wrong");
endmodule // loop_framer

// ===== design/loop_pkg.sv
// shared constants, types and helpers for the real-time loop framer
package loop_pkg;
  localparam int NUM_MOTORS = 4;
  // register byte offsets
  localparam logic [4:0] OFS_MOTOR0 = 5'h00;
  localparam logic [4:0] OFS_MOTOR1 = 5'h04;
  localparam logic [4:0] OFS_MOTOR2 = 5'h08;
  localparam logic [4:0] OFS_MOTOR3 = 5'h0c;
  localparam logic [4:0] OFS_GLOBAL = 5'h10;
  localparam logic [4:0] OFS_LOOP = 5'h14;
  localparam logic [4:0] OFS_STATUS = 5'h18;
  // per-motor flag bit positions
  localparam int F_CV = 0;
  localparam int F_CG = 1;
  localparam int F_FV = 2;
  localparam int F_FS = 3;
  localparam int F_FA = 4;
  localparam int F_FD = 5;
  // global bit positions, coefficient field positions, loop register in_loop bit
  localparam int G_TEMP = 0;
  localparam int G_DISCARD = 1;
  localparam int POS_CVC = 8;
  localparam int POS_FVC = 16;
  localparam int POS_DPC = 24;
  localparam int POS_IN_LOOP = 8;
  // reset values
  localparam logic [5:0] RST_FLAGS = 6'h00;
  localparam logic [7:0] RST_COEFF = 8'h01;
  // characters on the link
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_ETX = 8'h03;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_E = 8'h45;
  localparam logic [7:0] CH_R = 8'h52;
  localparam logic [7:0] CH_PROMPT = 8'h3e;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] HDR_CF = 8'h43;
  localparam logic [7:0] HDR_CA = 8'h63;
  localparam logic [7:0] HDR_NF = 8'h41;
  localparam logic [7:0] HDR_NA = 8'h61;
  // message lengths in bytes, divider step count
  localparam logic [2:0] LEN_ACK = 3'h1;
  localparam logic [2:0] LEN_ERR = 3'h6;
  localparam logic [2:0] LEN_PROMPT = 3'h1;
  localparam logic [4:0] DIV_STEPS = 5'h11;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0, S_MSG = 4'h1, S_SEND = 4'h3, S_HDR = 4'h2,
    S_CSEEK = 4'h6, S_CRECV = 4'h7, S_FSEEK = 4'h5, S_FDIV = 4'h4
  } fsm_type;
  typedef enum logic [1:0] {MSG_ACK = 2'h0, MSG_ERR = 2'h1, MSG_PROMPT = 2'h3} msg_type;

  // signed byte times unsigned coefficient, wraps to 16 bits
  function automatic logic signed [15:0] mul_coeff(input logic signed [7:0] v, input logic [7:0] c);
    logic signed [16:0] p;
    // widen both operands first so the product cannot wrap at operand width
    p = 17'(v) * $signed({9'h000, c});
    return p[15:0];
  endfunction

  // saturate a 17-bit signed value into one signed byte
  function automatic logic [7:0] clip8(input logic signed [16:0] v);
    if (v > 17'sd127) return 8'h7f;
    if (v < -17'sd128) return 8'h80;
    return v[7:0];
  endfunction

  // byte-enable merge for partial register writes
  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = d[i*8 +: 8];
    end
    return r;
  endfunction

  // coefficients live in 1..255, a zero write becomes one
  function automatic logic [7:0] nz(input logic [7:0] c);
    return (c == 8'h00) ? RST_COEFF : c;
  endfunction
endpackage

// ===== design/position_tracker.sv
// remembered reported position per motor for delta feedback
`timescale 1ns/1ps
module position_tracker #(
  parameter int MOTORS = 4
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic load,
  input wire logic update,
  input wire logic [1:0] motor,
  input wire logic [7:0] sent,
  input wire logic [7:0] coeff,
  input wire logic discard,
  input wire logic [MOTORS*16-1:0] position,
  output logic [MOTORS*16-1:0] reported
);
  import loop_pkg::*;
  typedef struct packed {
    logic [MOTORS-1:0][15:0] rep;
  } trk_state_type;
  trk_state_type st, next_st;

  ////////////////////////////////////////////////////////////////////////
  // load snapshots all motors on loop entry; update advances one motor
  always_comb begin
    next_st = st;
    if (load) begin
      next_st.rep = position;
    end else if (update) begin
      if (discard) next_st.rep[motor] = position[motor*16 +: 16];
      else next_st.rep[motor] = st.rep[motor] + mul_coeff(sent, coeff);
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) st <= '0;
    else st <= next_st;
  end

  assign reported = st.rep;

  a_discard_snap: assert property (@(posedge clock) disable iff (rst)
    (update && discard && !load) |=> st.rep[$past(motor)] == $past(position[motor*16 +: 16]))
    else $error("discard did not snap reported position");
endmodule // position_tracker

// ===== verification/host_link.sv
// host-side model of the byte link: sends control bytes, collects feedback bytes
`timescale 1ns/1ps
module host_link (
  input wire logic clock,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready
);
  logic slow = 1'b0;
  logic hs = 1'b0;
  logic [7:0] hd = 8'h00;
  logic [7:0] got[$];
  initial begin
    rx_data = 8'h00;
    rx_valid = 1'b0;
    tx_ready = 1'b0;
  end
  // sample mid-cycle so the capture never races the design's edge
  always @(negedge clock) begin
    hs <= tx_valid && tx_ready;
    hd <= tx_data;
  end
  // sink stalls every other cycle when slow
  always @(posedge clock) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (hs) got.push_back(hd);
  end
  // one byte per pulse, data scrambled after it
  task automatic send(input logic [7:0] b);
    @(posedge clock);
    rx_data <= b;
    rx_valid <= 1'b1;
    @(posedge clock);
    rx_valid <= 1'b0;
    rx_data <= ~b;
    repeat (2) @(posedge clock);
  endtask
endmodule // host_link

// ===== verification/tb_realtime_loop_block_framer.sv
// self-checking bench for the loop framer
`timescale 1ns/1ps
module tb_realtime_loop_block_framer;
  import loop_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [4:0] address = 5'h00;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, q;
  logic waitrequest, tx_valid, tx_ready, rx_valid, ctl_update, loop_active;
  logic [7:0] rx_data, tx_data;
  logic [63:0] motor_position = 64'h1234;
  logic [63:0] motor_velocity = 64'hffe2;
  logic err_event = 1'b0;
  logic [3:0] err_code = 4'h0;
  int n_upd = 0;
  logic [63:0] ctl_velocity;
  logic [31:0] ctl_gain;
  int n_errors = 0;
  int n_tests = 0;
  always #2.5 clock = ~clock;
  loop_framer u_loop_framer (.clock(clock), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(4'hf), .readdata(readdata), .waitrequest(waitrequest),
    .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .motor_velocity(motor_velocity), .motor_strain(32'h5577), .motor_position(motor_position),
    .temperature(16'hfe10), .err_event(err_event), .err_code(err_code), .ctl_velocity(ctl_velocity),
    .ctl_gain(ctl_gain), .ctl_update(ctl_update), .loop_active(loop_active));
  host_link u_host_link (.clock(clock), .rx_data(rx_data), .rx_valid(rx_valid), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  // count control update pulses mid-cycle, where they are settled
  always @(negedge clock) if (ctl_update === 1'b1) n_upd++;
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string s, input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("errors %0d tests %0d", n_errors, n_tests);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // request held until waitrequest is seen low, data taken then
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge clock);
    read <= !w;
    write <= w;
    address <= a;
    writedata <= d;
    k = 0;
    @(negedge clock);
    while (waitrequest !== 1'b0 && k < 50) begin
      @(negedge clock);
      k++;
    end
    @(posedge clock);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (k >= 50) begin
      chk("waitrequest", 32'h1, 32'h0);
      report_and_stop;
    end
  endtask
  task automatic expb(input logic [7:0] e[$]);
    int k;
    k = 0;
    while (u_host_link.got.size() < e.size() && k < 3000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 3000) begin
      n_errors++;
      report_and_stop;
    end
    foreach (e[i]) chk("tx byte", {24'h0, u_host_link.got[i]}, {24'h0, e[i]});
    u_host_link.got.delete();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, OFS_MOTOR0, 32'h0);
    chk("motor0 reset", q, 32'h01010100);
    bus(1'b0, 5'h1c, 32'h0);
    chk("unmapped", q, 32'h0);
    bus(1'b1, OFS_MOTOR0, 32'h0101023b);
    bus(1'b1, OFS_MOTOR1, 32'h00000008);
    bus(1'b0, OFS_MOTOR1, 32'h0);
    chk("zero coeff", q, 32'h01010108);
    bus(1'b1, OFS_GLOBAL, 32'h1);
    bus(1'b1, OFS_LOOP, 32'h1);
    expb('{CH_STAR});
    bus(1'b0, OFS_LOOP, 32'h0);
    chk("loop reg", q, 32'h101);
    bus(1'b1, OFS_MOTOR0, 32'h0);
    bus(1'b0, OFS_MOTOR0, 32'h0);
    chk("locked cfg", q, 32'h0101023b);
    motor_position <= 64'h1239;
    u_host_link.send(HDR_CF);
    u_host_link.send(8'hf8);
    u_host_link.send(8'h9a);
    expb('{CH_STAR, 8'h77, 8'h12, 8'h39, 8'h05, 8'hfe, 8'h10});
    chk("ctl vel", {16'h0, ctl_velocity[15:0]}, 32'hfff0);
    chk("ctl gain", {24'h0, ctl_gain[7:0]}, 32'h9a);
    u_host_link.slow <= 1'b1;
    u_host_link.send(HDR_CA);
    u_host_link.send(8'h08);
    u_host_link.send(8'h33);
    expb('{CH_STAR});
    chk("ctl vel", {16'h0, ctl_velocity[15:0]}, 32'h0010);
    chk("ctl gain", {24'h0, ctl_gain[7:0]}, 32'h33);
    u_host_link.send(HDR_NA);
    expb('{CH_STAR});
    u_host_link.send(HDR_NF);
    expb('{CH_STAR, 8'h77, 8'h12, 8'h39, 8'h00, 8'hfe, 8'h10});
    u_host_link.send(CH_ETX);
    expb('{CH_PROMPT});
    repeat (4) @(posedge clock);
    chk("loop active", {31'h0, loop_active}, 32'h0);
    chk("ctl updates", n_upd, 32'h2);
    // second loop: velocity feedback, overflow discard, then an error reply
    bus(1'b1, OFS_MOTOR0, 32'h0103023d);
    bus(1'b1, OFS_GLOBAL, 32'h3);
    bus(1'b1, OFS_LOOP, 32'h1);
    expb('{CH_STAR});
    motor_position <= 64'h1339;
    u_host_link.send(HDR_NF);
    expb('{CH_STAR, 8'hf6, 8'h77, 8'h13, 8'h39, 8'h7f, 8'hfe, 8'h10});
    u_host_link.send(HDR_NF);
    expb('{CH_STAR, 8'hf6, 8'h77, 8'h13, 8'h39, 8'h00, 8'hfe, 8'h10});
    @(posedge clock);
    err_event <= 1'b1;
    err_code <= 4'h5;
    @(posedge clock);
    err_event <= 1'b0;
    u_host_link.send(HDR_NA);
    expb('{CH_CR, CH_LF, CH_E, CH_R, CH_R, 8'h35});
    repeat (4) @(posedge clock);
    chk("loop active", {31'h0, loop_active}, 32'h0);
    report_and_stop;
  end
endmodule // tb_realtime_loop_block_framer
